//--- rtl/fcpl_pkg.sv
// package for the fast counter parameter loader
// assumes a single 200 MHz clock domain
package fcpl_pkg;
	// wishbone register offsets (byte addresses)
	localparam logic [7:0] OFS_COMMAND    = 8'h00;
	localparam logic [7:0] OFS_DATA       = 8'h04;
	localparam logic [7:0] OFS_CONFIG     = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
	localparam logic [7:0] OFS_TIMEBASE   = 8'h18;
	localparam logic [7:0] OFS_ON_PRESET  = 8'h1C;
	localparam logic [7:0] OFS_OFF_PRESET = 8'h20;
	localparam logic [7:0] OFS_PRELOAD    = 8'h24;
	localparam logic [7:0] OFS_ACCUM      = 8'h28;
	localparam logic [7:0] OFS_CPI        = 8'h2C;
	localparam logic [7:0] OFS_SLOT       = 8'h30;
	// command codes and identifiers
	localparam logic [7:0] CMD_TIMEBASE   = 8'h06;
	localparam logic [7:0] CMD_ON_PRESET  = 8'h0B;
	localparam logic [7:0] CMD_OFF_PRESET = 8'h15;
	localparam logic [7:0] CMD_PRELOAD    = 8'h1F;
	localparam logic [7:0] COUNTER_ID     = 8'h01;
	localparam logic [15:0] SLOT_ID       = 16'h0004;
	// config register fields
	localparam int CFG_ENABLE_BIT  = 0;
	localparam int CFG_STROBE_BIT  = 1;
	localparam int CFG_FALLING_BIT = 2;
	localparam int CFG_CLEAR_BIT   = 3;
	// status and irq fields
	localparam int ST_FAULT_BIT    = 0;
	localparam int ST_LATCH_BIT    = 1;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_FAULT_BIT   = 1;
	localparam int IRQ_LATCH_BIT   = 2;
	// reset values
	localparam logic [15:0] RST_TIMEBASE = 16'h03E8;
	localparam logic [15:0] RST_WORD     = 16'h0000;
	localparam logic [3:0]  RST_CONFIG   = 4'h0;
	// timing
	localparam int CLK_MHZ          = 200;
	localparam int STROBE_MIN_US    = 100;
	localparam int STROBE_MIN_CYC   = STROBE_MIN_US * CLK_MHZ;
	localparam int MS_US            = 1000;
	localparam int MS_CYC           = MS_US * CLK_MHZ;
	// command request carrier
	typedef struct packed {
		logic [7:0]  counter_id;
		logic [7:0]  code;
	} fcpl_cmd_t;
	typedef struct packed {
		logic        fault;
		logic        latch;
	} fcpl_status_t;
endpackage : fcpl_pkg

//--- rtl/fcpl_pulse_catch.sv
// pulse catch latch for one strobe input
// assumes strobe pin synchronous to sys_clk
`timescale 1ns/100ps
module fcpl_pulse_catch #(
	parameter int MIN_CYC = 20000
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// control
	input  wire logic arm,
	input  wire logic falling_edge_select,
	input  wire logic clear_bit,
	// strobe pin and latch
	input  wire logic strobe_in,
	output logic      capture_latch_status_bit,
	output logic      caught
);
	logic [15:0] width;
	logic        active;
	logic        clear_d;
	logic        clear_fall;

	// active level follows the chosen edge polarity
	assign active     = strobe_in ^ falling_edge_select;
	assign clear_fall = clear_d & ~clear_bit;
	assign caught     = arm && active && (width == 16'(MIN_CYC - 1));

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			width <= 16'h0000;
		end else if (!arm || !active) begin
			width <= 16'h0000;
		end else if (width != 16'(MIN_CYC)) begin
			width <= width + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clear_d <= 1'b0;
		end else begin
			clear_d <= clear_bit;
		end
	end

	// set wins over the one-then-zero clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_latch_status_bit <= 1'b0;
		end else if (caught) begin
			capture_latch_status_bit <= 1'b1;
		end else if (clear_fall) begin
			capture_latch_status_bit <= 1'b0;
		end
	end
endmodule : fcpl_pulse_catch

//--- rtl/fcpl_top.sv
// fast pulse counter parameter loader with strobe capture, wishbone slave
// assumes count, preload and strobe pins synchronous to sys_clk
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
module fcpl_top (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// counter pins
	input  wire logic        count_in,
	input  wire logic        preload_in,
	input  wire logic        strobe_in,
	// outputs
	output logic             counter_output,
	output logic             request_fault_output,
	output logic             capture_latch_status_bit,
	output logic             irq
);
	//////////////////////////////////////////////////////////////////////
	// registers
	fcpl_pkg::fcpl_cmd_t cmd;
	logic [15:0] data_word;
	logic [3:0]  config_bits;
	logic [15:0] timebase;
	logic [15:0] on_preset;
	logic [15:0] off_preset;
	logic [15:0] preload_value;
	logic [15:0] accum;
	logic [15:0] counts_per_interval_value;
	logic [15:0] interval_count;
	logic [15:0] interval_events;
	logic        interval_end;
	logic [15:0] target_slot_id;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;
	logic        count_d;
	logic        preload_d;
	logic [31:0] ms_div;
	logic        ms_tick;
	logic        caught;
	logic        bus_req;
	logic        wr;
	logic        cmd_go;
	logic        cmd_ok;
	logic        count_ev;
	logic        preload_ev;
	logic [31:0] next_rd;
	logic [2:0]  irq_set;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr      = bus_req && wb_we_i;
	// writing the command word executes the request, once per write
	assign cmd_go  = wr && (wb_adr_i == fcpl_pkg::OFS_COMMAND) && wb_sel_i[0];
	assign count_ev   = count_in && !count_d && config_bits[fcpl_pkg::CFG_ENABLE_BIT];
	assign preload_ev = preload_in && !preload_d && !config_bits[fcpl_pkg::CFG_STROBE_BIT];

	// id in upper byte, code in lower byte; task parameter has no port
	always_comb begin
		cmd_ok = 1'b0;
		if (wb_dat_i[15:8] == fcpl_pkg::COUNTER_ID &&
		    target_slot_id == fcpl_pkg::SLOT_ID) begin
			unique case (wb_dat_i[7:0])
				fcpl_pkg::CMD_TIMEBASE, fcpl_pkg::CMD_ON_PRESET,
				fcpl_pkg::CMD_OFF_PRESET, fcpl_pkg::CMD_PRELOAD: cmd_ok = 1'b1;
				default: cmd_ok = 1'b0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// wishbone ack and read data
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_comb begin
		next_rd = 32'h0000_0000;
		unique case (wb_adr_i)
			fcpl_pkg::OFS_COMMAND:    next_rd = {16'h0000, cmd};
			fcpl_pkg::OFS_DATA:       next_rd = {16'h0000, data_word};
			fcpl_pkg::OFS_CONFIG:     next_rd = {28'h0000000, config_bits};
			fcpl_pkg::OFS_STATUS:     next_rd = {30'h00000000, capture_latch_status_bit,
			                                     request_fault_output};
			fcpl_pkg::OFS_IRQ_STATUS: next_rd = {29'h00000000, irq_status};
			fcpl_pkg::OFS_IRQ_MASK:   next_rd = {29'h00000000, irq_mask};
			fcpl_pkg::OFS_TIMEBASE:   next_rd = {16'h0000, timebase};
			fcpl_pkg::OFS_ON_PRESET:  next_rd = {16'h0000, on_preset};
			fcpl_pkg::OFS_OFF_PRESET: next_rd = {16'h0000, off_preset};
			fcpl_pkg::OFS_PRELOAD:    next_rd = {16'h0000, preload_value};
			fcpl_pkg::OFS_ACCUM:      next_rd = {16'h0000, accum};
			fcpl_pkg::OFS_CPI:        next_rd = {16'h0000, counts_per_interval_value};
			fcpl_pkg::OFS_SLOT:       next_rd = {16'h0000, target_slot_id};
			default:                  next_rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rd;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// software written registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_word      <= fcpl_pkg::RST_WORD;
			config_bits    <= fcpl_pkg::RST_CONFIG;
			irq_mask       <= 3'h0;
			target_slot_id <= fcpl_pkg::RST_WORD;
			cmd            <= '0;
		end else if (wr) begin
			if (wb_adr_i == fcpl_pkg::OFS_DATA && wb_sel_i[0])
				data_word[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == fcpl_pkg::OFS_DATA && wb_sel_i[1])
				data_word[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == fcpl_pkg::OFS_CONFIG && wb_sel_i[0])
				config_bits <= wb_dat_i[3:0];
			if (wb_adr_i == fcpl_pkg::OFS_IRQ_MASK && wb_sel_i[0])
				irq_mask <= wb_dat_i[2:0];
			if (wb_adr_i == fcpl_pkg::OFS_SLOT && wb_sel_i[0] && wb_sel_i[1])
				target_slot_id <= wb_dat_i[15:0];
			if (cmd_go)
				cmd <= wb_dat_i[15:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// command execution: whole word loads in one edge, never half written
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			timebase      <= fcpl_pkg::RST_TIMEBASE;
			on_preset     <= fcpl_pkg::RST_WORD;
			off_preset    <= fcpl_pkg::RST_WORD;
			preload_value <= fcpl_pkg::RST_WORD;
		end else if (cmd_go && cmd_ok) begin
			unique case (wb_dat_i[7:0])
				fcpl_pkg::CMD_TIMEBASE:   timebase      <= data_word;
				fcpl_pkg::CMD_ON_PRESET:  on_preset     <= data_word;
				fcpl_pkg::CMD_OFF_PRESET: off_preset    <= data_word;
				fcpl_pkg::CMD_PRELOAD:    preload_value <= data_word;
				default: ;
			endcase
		end
	end

	// fault stands until the next accepted command
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			request_fault_output <= 1'b0;
		end else if (cmd_go) begin
			request_fault_output <= !cmd_ok;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// counting
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_d   <= 1'b0;
			preload_d <= 1'b0;
		end else begin
			count_d   <= count_in;
			preload_d <= preload_in;
		end
	end

	// preload beats a simultaneous count; that count is lost
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			accum <= fcpl_pkg::RST_WORD;
		end else if (preload_ev) begin
			accum <= preload_value;
		end else if (count_ev) begin
			accum <= accum + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			counter_output <= 1'b0;
		end else if (accum == on_preset) begin
			counter_output <= 1'b1;
		end else if (accum == off_preset) begin
			counter_output <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// counts per interval, millisecond base
	assign ms_tick = (ms_div == 32'(fcpl_pkg::MS_CYC - 1));

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_div <= 32'h0000_0000;
		end else if (ms_tick) begin
			ms_div <= 32'h0000_0000;
		end else begin
			ms_div <= ms_div + 32'h0000_0001;
		end
	end

	assign interval_end = ms_tick && (interval_count + 16'h0001 >= timebase);

	// counts of the running interval, not accumulator distance, so a preload
	// in mid-interval cannot upset the figure
	// 16-bit unsigned sum rolls over from 65535 to 0 by design
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			interval_count            <= fcpl_pkg::RST_WORD;
			interval_events           <= fcpl_pkg::RST_WORD;
			counts_per_interval_value <= fcpl_pkg::RST_WORD;
		end else if (interval_end) begin
			interval_count            <= fcpl_pkg::RST_WORD;
			interval_events           <= fcpl_pkg::RST_WORD;
			// a count on the closing edge still belongs to this interval
			counts_per_interval_value <= interval_events + {15'h0000, count_ev};
		end else begin
			if (ms_tick)
				interval_count <= interval_count + 16'h0001;
			if (count_ev)
				interval_events <= interval_events + 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// strobe capture
	fcpl_pulse_catch #(
		.MIN_CYC (fcpl_pkg::STROBE_MIN_CYC)
	) u_catch (
		.sys_clk                  (sys_clk),
		.reset_n                  (reset_n),
		.arm                      (config_bits[fcpl_pkg::CFG_STROBE_BIT] &&
		                           config_bits[fcpl_pkg::CFG_ENABLE_BIT]),
		.falling_edge_select      (config_bits[fcpl_pkg::CFG_FALLING_BIT]),
		.clear_bit                (config_bits[fcpl_pkg::CFG_CLEAR_BIT]),
		.strobe_in                (strobe_in),
		.capture_latch_status_bit (capture_latch_status_bit),
		.caught                   (caught)
	);

	//////////////////////////////////////////////////////////////////////
	// interrupts, write one to clear, set wins
	assign irq_set = {caught, cmd_go && !cmd_ok, cmd_go && cmd_ok};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= 3'h0;
		end else begin
			if (wr && wb_adr_i == fcpl_pkg::OFS_IRQ_STATUS && wb_sel_i[0])
				irq_status <= (irq_status & ~wb_dat_i[2:0]) | irq_set;
			else
				irq_status <= irq_status | irq_set;
		end
	end

	assign irq = |(irq_status & irq_mask);
endmodule : fcpl_top

//--- verification/fcpl_cpu_model.sv
// controller cpu model: wishbone cycles and command requests
// assumes the block acks every request; the bench timeout ends a hang
`timescale 1ns/100ps
module fcpl_cpu_model (
	// clock
	input  wire logic        sys_clk,
	// wishbone master
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic      [7:0]  wb_adr_o,
	output logic      [3:0]  wb_sel_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'hFF;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge sys_clk);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'hF;
		wb_dat_o <= wd;
		do @(posedge sys_clk); while (wb_ack_i !== 1'b1);
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// released address and data lines carry junk, never the stale value
		wb_adr_o <= ~adr;
		wb_dat_o <= ~wd;
	endtask : bus
	// one request per call, data word first, no task parameter sent
	task automatic cmd(input logic [7:0] id, input logic [7:0] code, input logic [15:0] data);
		logic [31:0] unused;
		bus(1'b1, fcpl_pkg::OFS_DATA, {16'h0, data}, unused);
		bus(1'b1, fcpl_pkg::OFS_COMMAND, {16'h0, id, code}, unused);
	endtask : cmd
endmodule : fcpl_cpu_model

//--- verification/fcpl_properties.sv
// port assertions for fcpl_top
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/100ps
module fcpl_checker (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pins
	input wire logic        strobe_in,
	input wire logic        request_fault_output,
	input wire logic        capture_latch_status_bit,
	input wire logic        irq
);
	// slack of 8 cycles allows for pin synchronisers
	localparam int MIN_RUN = fcpl_pkg::STROBE_MIN_CYC - 8;
	int   run, prev_run, cmd_hold, cfg_hold;
	logic strobe_q, taken, cmd_w, cfg_w;
	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_w = taken && wb_we_i && wb_adr_i == fcpl_pkg::OFS_COMMAND;
	assign cfg_w = taken && wb_we_i && wb_adr_i == fcpl_pkg::OFS_CONFIG;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			run      <= 0;
			prev_run <= 0;
			strobe_q <= 1'b0;
			cmd_hold <= 0;
			cfg_hold <= 0;
		end else begin
			strobe_q <= strobe_in;
			run      <= (strobe_in != strobe_q) ? 0 : run + int'(run < MIN_RUN);
			prev_run <= (strobe_in != strobe_q) ? run : prev_run;
			cmd_hold <= cmd_w ? 3 : cmd_hold - int'(cmd_hold > 0);
			cfg_hold <= cfg_w ? 6 : cfg_hold - int'(cfg_hold > 0);
		end
	end
	property p_ack_resp; taken |=> wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_rd_unmapped; taken && !wb_we_i && wb_adr_i == 8'h3C |=> wb_dat_o == 32'h0; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_upper_zero; wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0; endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_bad_id;
		cmd_w && wb_dat_i[15:8] != fcpl_pkg::COUNTER_ID |-> ##[1:2] request_fault_output;
	endproperty
	a_bad_id: assert property (p_bad_id) else $error("bad id not faulted");
	property p_fault_cause; $changed(request_fault_output) |-> cmd_hold != 0; endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault moved without command");
	property p_latch_min; $rose(capture_latch_status_bit) |-> run >= MIN_RUN || prev_run >= MIN_RUN;
	endproperty
	a_latch_min: assert property (p_latch_min) else $error("latch set by short pulse");
	property p_latch_clear; $fell(capture_latch_status_bit) |-> cfg_hold != 0; endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch fell without clear");
	c_latch: cover property ($rose(capture_latch_status_bit));
	c_fault: cover property ($rose(request_fault_output));
	c_irq: cover property ($rose(irq));
endmodule : fcpl_checker
bind fcpl_top fcpl_checker fcpl_checker_inst (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strobe_in, .request_fault_output,
	.capture_latch_status_bit, .irq);

//--- verification/fcpl_top_tb.sv
// self-checking bench for fcpl_top
// assumes the cpu model and checker are compiled before it
`timescale 1ns/100ps
module fcpl_top_tb;
	logic        sys_clk, reset_n, count_in, preload_in, strobe_in;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, counter_output;
	logic        request_fault_output, capture_latch_status_bit, irq;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int          n_mismatch = 0;
	int          num_checks = 0;
	logic [7:0]  codes [4] = '{8'h06, 8'h0B, 8'h15, 8'h1F};
	logic [7:0]  offs [4] = '{8'h18, 8'h1C, 8'h20, 8'h24};
	logic [15:0] words [4] = '{16'h0258, 16'h1388, 16'h2EE0, 16'h25A0};
	fcpl_top fcpl_top_inst (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_in, .preload_in, .strobe_in,
		.counter_output, .request_fault_output, .capture_latch_status_bit, .irq);
	fcpl_cpu_model fcpl_cpu_model_inst (.sys_clk, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
		.wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
		.wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		fcpl_cpu_model_inst.bus(1'b1, adr, d, rd);
	endtask : wr
	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		fcpl_cpu_model_inst.bus(1'b0, adr, 32'h0, rd);
		chk(rd, exp);
	endtask : rdchk
	// sample pins on falling edges, well clear of updates
	task automatic settle();
		repeat (2) @(negedge sys_clk);
	endtask : settle
	task automatic pin_pulse(input logic pre);
		@(posedge sys_clk);
		{preload_in, count_in} <= pre ? 2'b10 : 2'b01;
		repeat (4) @(posedge sys_clk);
		{preload_in, count_in} <= 2'b00;
		settle();
	endtask : pin_pulse
	task automatic strobe_run(input logic lvl, input int n);
		@(posedge sys_clk);
		strobe_in <= lvl;
		repeat (n) @(posedge sys_clk);
		strobe_in <= ~lvl;
		settle();
	endtask : strobe_run
	task automatic t_bad();
		fcpl_cpu_model_inst.cmd(8'h02, 8'h06, 16'h1234);
		rdchk(8'h0C, 32'h1);
		wr(8'h30, 32'h4);
		fcpl_cpu_model_inst.cmd(8'h01, 8'h01, 16'h1234);
		rdchk(8'h18, 32'h03E8);
		wr(8'h30, 32'h5);
		fcpl_cpu_model_inst.cmd(8'h01, 8'h06, 16'h1234);
		rdchk(8'h18, 32'h03E8);
		chk(request_fault_output, 1'b1);
		rdchk(8'h10, 32'h2);
		wr(8'h14, 32'h2);
		settle();
		chk(irq, 1'b1);
		wr(8'h10, 32'h7);
		settle();
		chk(irq, 1'b0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rdchk(8'h3C, 32'h0);
		$display("test bad requests done");
	endtask : t_bad
	task automatic t_load();
		wr(8'h30, 32'h4);
		for (int i = 0; i < 4; i++) begin
			fcpl_cpu_model_inst.cmd(8'h01, codes[i], words[i]);
			rdchk(offs[i], {16'h0, words[i]});
			chk(request_fault_output, 1'b0);
		end
		rdchk(8'h10, 32'h1);
		$display("test parameter loads done");
	endtask : t_load
	task automatic t_pins();
		wr(8'h08, 32'h1);
		for (int i = 0; i < 3; i++)
			pin_pulse(i == 0);
		rdchk(8'h28, 32'h25A2);
		fcpl_cpu_model_inst.cmd(8'h01, 8'h1F, 16'h1387);
		pin_pulse(1'b1);
		chk(counter_output, 1'b0);
		pin_pulse(1'b0);
		chk(counter_output, 1'b1);
		fcpl_cpu_model_inst.cmd(8'h01, 8'h1F, 16'h2EDF);
		pin_pulse(1'b1);
		chk(counter_output, 1'b1);
		pin_pulse(1'b0);
		chk(counter_output, 1'b0);
		$display("test preload pin done");
	endtask : t_pins
	task automatic t_strobe();
		wr(8'h08, 32'h3);
		pin_pulse(1'b1);
		rdchk(8'h28, 32'h2EE0);
		strobe_run(1'b1, 1000);
		chk(capture_latch_status_bit, 1'b0);
		strobe_run(1'b1, fcpl_pkg::STROBE_MIN_CYC + 100);
		chk(capture_latch_status_bit, 1'b1);
		rdchk(8'h0C, 32'h2);
		wr(8'h14, 32'h4);
		settle();
		chk(irq, 1'b1);
		wr(8'h08, 32'hB);
		wr(8'h08, 32'h3);
		settle();
		chk(capture_latch_status_bit, 1'b0);
		wr(8'h08, 32'h7);
		strobe_in <= 1'b1;
		strobe_run(1'b0, fcpl_pkg::STROBE_MIN_CYC + 100);
		chk(capture_latch_status_bit, 1'b1);
		$display("test strobe capture done");
	endtask : t_strobe
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	initial begin
		#(5 * 60000);
		n_mismatch++;
		summarize();
	end
	initial begin
		reset_n    = 1'b0;
		count_in   = 1'b0;
		preload_in = 1'b0;
		strobe_in  = 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk(8'h18, 32'h03E8);
		t_bad();
		t_load();
		t_pins();
		t_strobe();
		summarize();
	end
endmodule : fcpl_top_tb
